// File: core/scs_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - Chip-select on step drives select low and keeps it low until an off step.
// - Chip-select off step drives select high, ending the flash transaction.
// - Write step shifts exactly the counted bytes out, in stream order; max 16.
// - Buffered read stores count bytes from SPI into scratch from the offset; max 16.
// - Buffered write sends count scratch bytes from the offset; max 16.
// - AND step replaces the indexed scratch byte with its AND against the value.
// - OR step replaces the indexed scratch byte with its OR against the value.
// - XOR step replaces the indexed scratch byte with its XOR against the value.
// - Init list runs during connect, before any programming.
// - Exit list runs only after programming has completed.
module scs_sequencer
   import scs_pkg::*;
#(
   parameter int MsTicks = SCS_TICKS_MS
)
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // Host control
   input  wire logic                       connectReq,
   input  wire logic                       progDone,
   output logic                            initDone,
   output logic                            exitDone,
   output logic                            busy,
   output logic                            stepError,
   // Step lists, loaded by the host
   input  wire scs_pkg::scs_step_t         initSteps [SCS_MAX_STEPS],
   input  wire logic [SCS_STEP_W:0]        numInitSteps,
   input  wire scs_pkg::scs_step_t         exitSteps [SCS_MAX_STEPS],
   input  wire logic [SCS_STEP_W:0]        numExitSteps,
   // Byte stream of write steps
   input  wire logic [7:0]                 streamByte,
   input  wire logic                       streamValid,
   output logic                            streamTake,
   // Scratch buffer view
   output logic [7:0]                      scratchOut [SCS_BUF_BYTES],
   // SPI pins
   output scs_pkg::scs_spi_t               spi,
   input  wire logic                       miso
);
   import scs_pkg::*;

   typedef enum logic [6:0] {
      S_IDLE  = 7'b0000001,
      S_FETCH = 7'b0000010,
      S_EXEC  = 7'b0000100,
      S_BYTE  = 7'b0001000,
      S_WAITB = 7'b0010000,
      S_DELAY = 7'b0100000,
      S_NEXT  = 7'b1000000
   } scs_state_t;

   scs_state_t            st_q, st_d;
   logic                  inExit_q, inExit_d;
   logic [SCS_STEP_W:0]   idx_q, idx_d;
   scs_step_t             cur_q, cur_d;
   logic [SCS_CNT_W-1:0]  cnt_q, cnt_d;
   logic [3:0]            pos_q, pos_d;
   logic [15:0]           ms_q, ms_d;
   logic [31:0]           tick_q, tick_d;
   logic                  csN_q, csN_d;
   logic                  initDone_q, initDone_d;
   logic                  exitDone_q, exitDone_d;
   logic                  err_q, err_d;
   logic                  take_q, take_d;
   logic                  busy_q, busy_d;
   logic                  cntOver;
   logic [7:0]            buf_q [SCS_BUF_BYTES];
   logic [7:0]            buf_d [SCS_BUF_BYTES];
   logic                  shStart;
   logic [7:0]            shTx;
   logic                  shDone;
   logic [7:0]            shRx;
   logic                  sckW;
   logic                  mosiW;
   logic [SCS_STEP_W:0]   listLen;
   scs_step_t             listStep;

   assign listLen  = inExit_q ? numExitSteps : numInitSteps;
   assign listStep = inExit_q ? exitSteps[idx_q[SCS_STEP_W-1:0]]
                              : initSteps[idx_q[SCS_STEP_W-1:0]];

   scs_byte_shifter u_shift (
      .clk    (clk),
      .rst    (rst),
      .start  (shStart),
      .txByte (shTx),
      .done   (shDone),
      .rxByte (shRx),
      .sck    (sckW),
      .mosi   (mosiW),
      .miso   (miso)
   );

   always_comb begin
      st_d       = st_q;
      inExit_d   = inExit_q;
      idx_d      = idx_q;
      cur_d      = cur_q;
      cnt_d      = cnt_q;
      pos_d      = pos_q;
      ms_d       = ms_q;
      tick_d     = tick_q;
      csN_d      = csN_q;
      initDone_d = initDone_q;
      exitDone_d = exitDone_q;
      err_d      = err_q;
      take_d     = 1'b0;
      buf_d      = buf_q;
      shStart    = 1'b0;
      shTx       = 8'h00;
      // Full-width count test, so a large count cannot wrap into range
      cntOver    = (cur_q.op == SCS_OP_WRITE) ? (cur_q.value0 > 16'(SCS_MAX_COUNT))
                                              : (cur_q.value1 > 8'(SCS_MAX_COUNT));
      // Disconnect clears the done flags; a same-cycle finish still sets them
      if (!connectReq) begin
         initDone_d = 1'b0;
         exitDone_d = 1'b0;
      end
      case (st_q)
         S_IDLE: begin
            if (connectReq && !initDone_q) begin
               inExit_d = 1'b0;
               idx_d    = '0;
               st_d     = S_FETCH;
            end else if (progDone && initDone_q && !exitDone_q) begin
               inExit_d = 1'b1;
               idx_d    = '0;
               st_d     = S_FETCH;
            end
         end
         S_FETCH: begin
            if (idx_q >= listLen) begin
               if (inExit_q) begin
                  exitDone_d = 1'b1;
               end else begin
                  initDone_d = 1'b1;
               end
               st_d = S_IDLE;
            end else begin
               cur_d = listStep;
               st_d  = S_EXEC;
            end
         end
         S_EXEC: begin
            pos_d = cur_q.value0[3:0];
            cnt_d = (cur_q.op == SCS_OP_WRITE) ? cur_q.value0[SCS_CNT_W-1:0]
                                               : cur_q.value1[SCS_CNT_W-1:0];
            st_d  = S_NEXT;
            case (cur_q.op)
               SCS_OP_DELAY: begin
                  ms_d   = cur_q.value0;
                  tick_d = '0;
                  st_d   = S_DELAY;
               end
               SCS_OP_CS_ON:  csN_d = 1'b0;
               SCS_OP_CS_OFF: csN_d = 1'b1;
               SCS_OP_WRITE, SCS_OP_VREAD, SCS_OP_VWRITE: begin
                  if (cntOver) begin
                     err_d = 1'b1;
                  end else begin
                     st_d = S_BYTE;
                  end
               end
               SCS_OP_VAND: buf_d[cur_q.value0[3:0]] =
                  buf_q[cur_q.value0[3:0]] & cur_q.value1;
               SCS_OP_VOR:  buf_d[cur_q.value0[3:0]] =
                  buf_q[cur_q.value0[3:0]] | cur_q.value1;
               SCS_OP_VXOR: buf_d[cur_q.value0[3:0]] =
                  buf_q[cur_q.value0[3:0]] ^ cur_q.value1;
               default: err_d = 1'b1;
            endcase
         end
         S_BYTE: begin
            if (cnt_q == '0) begin
               st_d = S_NEXT;
            end else if (cur_q.op == SCS_OP_WRITE) begin
               if (streamValid) begin
                  shStart = 1'b1;
                  shTx    = streamByte;
                  take_d  = 1'b1;
                  st_d    = S_WAITB;
               end
            end else begin
               shStart = 1'b1;
               shTx    = (cur_q.op == SCS_OP_VWRITE) ? buf_q[pos_q] : 8'hFF;
               st_d    = S_WAITB;
            end
         end
         S_WAITB: begin
            if (shDone) begin
               if (cur_q.op == SCS_OP_VREAD) begin
                  buf_d[pos_q] = shRx;
               end
               pos_d = pos_q + 4'h1;
               cnt_d = cnt_q - 5'h01;
               st_d  = S_BYTE;
            end
         end
         S_DELAY: begin
            if (ms_q == '0) begin
               st_d = S_NEXT;
            end else if (tick_q == 32'(MsTicks - 1)) begin
               tick_d = '0;
               ms_d   = ms_q - 16'h0001;
            end else begin
               tick_d = tick_q + 32'h1;
            end
         end
         S_NEXT: begin
            idx_d = idx_q + 1'b1;
            st_d  = S_FETCH;
         end
         default: st_d = S_IDLE;
      endcase
      busy_d = (st_d != S_IDLE);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q       <= S_IDLE;
         inExit_q   <= 1'b0;
         idx_q      <= '0;
         cur_q      <= '0;
         cnt_q      <= '0;
         pos_q      <= '0;
         ms_q       <= '0;
         tick_q     <= '0;
         csN_q      <= 1'b1;
         initDone_q <= 1'b0;
         exitDone_q <= 1'b0;
         err_q      <= 1'b0;
         take_q     <= 1'b0;
         busy_q     <= 1'b0;
         for (int i = 0; i < SCS_BUF_BYTES; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else begin
         st_q       <= st_d;
         inExit_q   <= inExit_d;
         idx_q      <= idx_d;
         cur_q      <= cur_d;
         cnt_q      <= cnt_d;
         pos_q      <= pos_d;
         ms_q       <= ms_d;
         tick_q     <= tick_d;
         csN_q      <= csN_d;
         initDone_q <= initDone_d;
         exitDone_q <= exitDone_d;
         err_q      <= err_d;
         take_q     <= take_d;
         busy_q     <= busy_d;
         buf_q      <= buf_d;
      end
   end

   assign initDone   = initDone_q;
   assign exitDone   = exitDone_q;
   assign busy       = busy_q;
   assign stepError  = err_q;
   assign streamTake = take_q;
   assign scratchOut = buf_q;
   assign spi.csN    = csN_q;
   assign spi.sck    = sckW;
   assign spi.mosi   = mosiW;
endmodule

// File: core/scs_pkg.sv
package scs_pkg;

   // Step opcodes
   typedef enum logic [3:0] {
      SCS_OP_DELAY   = 4'h0,
      SCS_OP_CS_ON   = 4'h1,
      SCS_OP_CS_OFF  = 4'h2,
      SCS_OP_WRITE   = 4'h3,
      SCS_OP_VREAD   = 4'h4,
      SCS_OP_VWRITE  = 4'h5,
      SCS_OP_VAND    = 4'h6,
      SCS_OP_VOR     = 4'h7,
      SCS_OP_VXOR    = 4'h8
   } scs_op_t;

   localparam int SCS_BUF_BYTES  = 16;
   localparam int SCS_MAX_STEPS  = 16;
   localparam int SCS_STEP_W     = 4;
   localparam int SCS_CNT_W      = 5;

   // Timing
   localparam int SCS_CLK_HZ     = 20000000;
   localparam int SCS_MS_PER_S   = 1000;
   localparam int SCS_TICKS_MS   = SCS_CLK_HZ / SCS_MS_PER_S;
   localparam int SCS_SCK_HALF   = 2;

   localparam logic [4:0] SCS_MAX_COUNT = 5'h10;

   // One step of a list
   typedef struct packed {
      scs_op_t    op;
      logic [15:0] value0;
      logic [7:0]  value1;
   } scs_step_t;

   // SPI pins toward the flash
   typedef struct packed {
      logic csN;
      logic sck;
      logic mosi;
   } scs_spi_t;

endpackage

// File: core/scs_byte_shifter.sv
`timescale 1ns/1ps
module scs_byte_shifter
   import scs_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Byte request
   input  wire logic       start,
   input  wire logic [7:0] txByte,
   output logic            done,
   output logic [7:0]      rxByte,
   // SPI data pins
   output logic            sck,
   output logic            mosi,
   input  wire logic       miso
);
   import scs_pkg::*;

   // Mode 0, MSB first
   logic       busy_q, busy_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] rx_q, rx_d;
   logic [1:0] div_q, div_d;
   logic       sck_q, sck_d;
   logic       done_q, done_d;

   always_comb begin
      busy_d = busy_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      rx_d   = rx_q;
      div_d  = div_q;
      sck_d  = sck_q;
      done_d = 1'b0;
      if (!busy_q) begin
         if (start) begin
            busy_d = 1'b1;
            sh_d   = txByte;
            bit_d  = 3'h7;
            div_d  = 2'h0;
         end
      end else if (div_q == 2'(SCS_SCK_HALF - 1)) begin
         div_d = 2'h0;
         sck_d = !sck_q;
         if (!sck_q) begin
            rx_d = {rx_q[6:0], miso};
         end else begin
            sh_d  = {sh_q[6:0], 1'b0};
            bit_d = bit_q - 3'h1;
            if (bit_q == 3'h0) begin
               busy_d = 1'b0;
               done_d = 1'b1;
            end
         end
      end else begin
         div_d = div_q + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q <= 1'b0;
         bit_q  <= 3'h0;
         sh_q   <= 8'h00;
         rx_q   <= 8'h00;
         div_q  <= 2'h0;
         sck_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         bit_q  <= bit_d;
         sh_q   <= sh_d;
         rx_q   <= rx_d;
         div_q  <= div_d;
         sck_q  <= sck_d;
         done_q <= done_d;
      end
   end

   assign done   = done_q;
   assign rxByte = rx_q;
   assign sck    = sck_q;
   assign mosi   = sh_q[7];
endmodule

// File: verif/scs_seq_sva.sv
`timescale 1ns/1ps
module scs_seq_sva
   import scs_pkg::*;
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // Control and stream
   input wire logic              connectReq,
   input wire logic              progDone,
   input wire logic              initDone,
   input wire logic              exitDone,
   input wire logic              busy,
   input wire logic              stepError,
   input wire logic              streamValid,
   input wire logic              streamTake,
   // SPI pins
   input wire scs_pkg::scs_spi_t spi
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_init_start: assert property ($rose(busy) && !initDone |-> connectReq)
      else $error("list started without connect");
   a_exit_start: assert property ($rose(busy) && initDone |-> progDone && !exitDone)
      else $error("exit list started early");
   a_exit_done: assert property ($rose(exitDone) |-> progDone && initDone)
      else $error("exit done without programming");
   a_sck_shape: assert property ($rose(spi.sck) |=> spi.sck ##1 !spi.sck)
      else $error("clock high phase wrong");
   a_idle_quiet: assert property (!busy |-> !spi.sck)
      else $error("clock toggles while idle");
   a_idle_select: assert property (!busy && !$past(busy) |-> $stable(spi.csN))
      else $error("select moved while idle");
   a_bit_stable: assert property (spi.sck |-> $stable(spi.csN) && $stable(spi.mosi))
      else $error("pins moved in high phase");
   a_take_pulse: assert property (streamTake |=> !streamTake)
      else $error("take longer than one cycle");
   a_take_cause: assert property (streamTake |-> $past(streamValid) || $past(streamValid, 2))
      else $error("byte taken without valid");
   a_err_sticky: assert property (stepError |=> stepError)
      else $error("error flag dropped");
   c_init: cover property ($rose(initDone));
   c_exit: cover property ($rose(exitDone));
   c_err: cover property ($rose(stepError));
endmodule

// File: verif/scs_flash_model.sv
`timescale 1ns/1ps
module scs_flash_model
   import scs_pkg::*;
(
   input wire scs_pkg::scs_spi_t spi,
   output logic                  miso
);
   logic [7:0] sh;
   logic [7:0] tx;
   logic [7:0] cur;
   logic [7:0] got [$];
   logic [7:0] sent [$];
   int         bitN = 0;
   int         byteN = 0;
   initial miso = 1'b1;
   // Frame start loads the first reply byte
   always @(negedge spi.csN) begin
      bitN = 0;
      byteN = 0;
      cur = 8'hC3;
      tx = cur;
      miso = tx[7];
   end
   // Mode 0: sample on rise, shift on fall
   always @(posedge spi.sck) if (spi.csN === 1'b0) begin
      sh = {sh[6:0], spi.mosi};
      bitN++;
      if (bitN == 8) begin
         got.push_back(sh);
         sent.push_back(cur);
         bitN = 0;
         byteN++;
      end
   end
   always @(negedge spi.sck) if (spi.csN === 1'b0) begin
      if (bitN == 0) begin
         cur = 8'hC3 + 8'(byteN * 37);
         tx = cur;
      end else
         tx = tx << 1;
      miso = tx[7];
   end
   // Released line shows no stale level
   always @(posedge spi.csN) miso = ~miso;
endmodule

// File: verif/test_spi_custom_command_sequencer.sv
`timescale 1ns/1ps
module test_spi_custom_command_sequencer;
   import scs_pkg::*;
   localparam int MS = 4;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                connectReq = 1'b0;
   logic                progDone = 1'b0;
   logic                initDone, exitDone, busy, stepError, streamTake, miso;
   logic [7:0]          streamByte = 8'h00;
   logic                streamValid = 1'b0;
   logic [7:0]          scratchOut [SCS_BUF_BYTES];
   scs_spi_t            spi;
   scs_step_t           iS [SCS_MAX_STEPS];
   scs_step_t           eS [SCS_MAX_STEPS];
   logic [SCS_STEP_W:0] nI = 5'h0C;
   logic [SCS_STEP_W:0] nE = 5'h04;
   logic [15:0]         rnd = 16'h4417;
   logic [7:0]          sQ [$];
   logic [7:0]          expQ [$];
   logic [7:0]          sc [16];
   realtime             tRise = 0;
   realtime             gap = 0;
   int                  failures = 0;
   int                  total_checks = 0;
   int                  sIdx = 0;
   int                  n;

   scs_sequencer #(.MsTicks(MS)) u_dut (.clk(clk), .rst(rst), .connectReq(connectReq),
      .progDone(progDone), .initDone(initDone), .exitDone(exitDone), .busy(busy),
      .stepError(stepError), .initSteps(iS), .numInitSteps(nI), .exitSteps(eS),
      .numExitSteps(nE), .streamByte(streamByte), .streamValid(streamValid),
      .streamTake(streamTake), .scratchOut(scratchOut), .spi(spi), .miso(miso));
   scs_flash_model u_fl (.spi(spi), .miso(miso));

   function automatic logic [15:0] lf(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic scs_step_t mk(scs_op_t o, int a, int b);
      return {o, 16'(a), 8'(b)};
   endfunction
   task automatic chk(input bit ok, input string m);
      total_checks++;
      if (!ok) begin
         failures++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic cmpAll(input string m);
      for (int i = 0; i < 16; i++) chk(scratchOut[i] === sc[i], m);
      chk(u_fl.got.size() == expQ.size(), m);
      foreach (expQ[i]) chk(u_fl.got[i] === expQ[i], m);
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always #25 clk = ~clk;
   // Stream source with random stalls
   always @(posedge clk) begin
      #1;
      if (streamTake === 1'b1) sIdx++;
      rnd = lf(rnd);
      // Valid holds until the byte is taken
      if (streamTake === 1'b1 || streamValid !== 1'b1) streamValid = rnd[0];
      streamByte = (sIdx < sQ.size()) ? sQ[sIdx] : 8'h00;
   end
   always @(posedge spi.csN) tRise = $realtime;
   always @(negedge spi.csN) gap = $realtime - tRise;

   initial begin
      for (n = 0; n < SCS_MAX_STEPS; n++) begin
         iS[n] = '0;
         eS[n] = '0;
      end
      for (n = 0; n < 16; n++) sc[n] = 8'h00;
      for (n = 0; n < 4; n++) begin
         rnd = lf(rnd);
         sQ.push_back(rnd[7:0]);
      end
      iS[0] = mk(SCS_OP_CS_ON, 0, 0);
      iS[1] = mk(SCS_OP_WRITE, 3, 0);
      iS[2] = mk(SCS_OP_VREAD, 14, 4);
      iS[3] = mk(SCS_OP_VAND, 14, rnd[15:8]);
      iS[4] = mk(SCS_OP_VOR, 15, rnd[11:4]);
      iS[5] = mk(SCS_OP_VXOR, 0, rnd[13:6]);
      iS[6] = mk(SCS_OP_VWRITE, 15, 3);
      iS[7] = mk(SCS_OP_CS_OFF, 0, 0);
      iS[8] = mk(SCS_OP_DELAY, 2, 0);
      iS[9] = mk(SCS_OP_WRITE, 17, 0);
      iS[10] = mk(SCS_OP_CS_ON, 0, 0);
      iS[11] = mk(SCS_OP_CS_OFF, 0, 0);
      eS[0] = mk(SCS_OP_CS_ON, 0, 0);
      eS[1] = mk(SCS_OP_WRITE, 1, 0);
      eS[2] = mk(SCS_OP_VREAD, 0, 16);
      eS[3] = mk(SCS_OP_CS_OFF, 0, 0);
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      connectReq = 1'b1;
      repeat (4000) if (initDone !== 1'b1) @(posedge clk) #1;
      sc[14] = u_fl.sent[3] & iS[3][7:0];
      sc[15] = u_fl.sent[4] | iS[4][7:0];
      sc[0] = u_fl.sent[5] ^ iS[5][7:0];
      sc[1] = u_fl.sent[6];
      for (n = 0; n < 3; n++) expQ.push_back(sQ[n]);
      repeat (4) expQ.push_back(8'hFF);
      expQ.push_back(sc[15]);
      expQ.push_back(sc[0]);
      expQ.push_back(sc[1]);
      chk(initDone === 1'b1, "init list not done");
      chk(busy === 1'b0, "busy after init list");
      chk(stepError === 1'b1, "oversize count accepted");
      chk(spi.csN === 1'b1, "select left low");
      chk(gap >= 2 * MS * 50 && gap <= (2 * MS + 30) * 50, "delay span wrong");
      cmpAll("init traffic or scratch wrong");
      repeat (50) @(posedge clk);
      #1 chk(exitDone === 1'b0, "exit ran before programming");
      progDone = 1'b1;
      repeat (8000) if (exitDone !== 1'b1) @(posedge clk) #1;
      expQ.push_back(sQ[3]);
      for (n = 0; n < 16; n++) begin
         sc[n] = u_fl.sent[11 + n];
         expQ.push_back(8'hFF);
      end
      chk(exitDone === 1'b1, "exit list not done");
      chk(busy === 1'b0, "busy after exit list");
      chk(spi.csN === 1'b1, "select left low");
      cmpAll("exit traffic or scratch wrong");
      // Disconnect clears both done flags
      connectReq = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(initDone === 1'b0 && exitDone === 1'b0, "flags kept after disconnect");
      end_sim();
   end
   initial begin
      #1000000;
      failures++;
      end_sim();
   end
endmodule
bind scs_sequencer scs_seq_sva u_sva (.clk(clk), .rst(rst), .connectReq(connectReq),
   .progDone(progDone), .initDone(initDone), .exitDone(exitDone), .busy(busy),
   .stepError(stepError), .streamValid(streamValid), .streamTake(streamTake), .spi(spi));
